/* File: pkg/umt_pkg.sv */
// Purpose: Shared constants for the user-mode trap logic
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses; reset values apply under presetn
package umt_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_MASK = 12'h004;
    localparam logic [11:0] OFS_CTRL = 12'h008;
    localparam logic [11:0] OFS_STATE = 12'h00c;
    // Status and mask bit positions
    localparam int EV_TRAP = 0;
    localparam int EV_SKIP = 1;
    localparam int EV_ENTRY = 2;
    localparam int EV_USER = 3;
    localparam int EV_W = 4;
    // Control bit positions
    localparam int CT_INT_EN = 0;
    localparam int CT_SOFT_CLR = 1;
    // State register bit positions
    localparam int ST_ACTIVE = 0;
    localparam int ST_PENDING = 1;
    localparam int ST_SAVED = 2;
    localparam int ST_TRAP = 3;
    localparam int ST_INHIBIT = 4;
    localparam int ST_INTCYC = 5;
    localparam int ST_W = 6;
    // Reset values
    localparam logic [EV_W-1:0] RST_STATUS = 4'h0;
    localparam logic [EV_W-1:0] RST_MASK = 4'h0;
    localparam logic RST_INT_EN = 1'b1;
    localparam logic [31:0] RST_PRDATA = 32'h0000_0000;
    // Bus address width seen by the decoder
    localparam int ADDR_W = 12;
endpackage

/* File: logic/umt_trap.sv */
// Purpose: Executive/user mode flags and user trap logic with an APB view
// Assumes: Decoded instruction levels and timing pulses come from core logic on pclk
// Notes: Bus levels are active low and driven open-drain through an enable
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps

module umt_trap (
    input wire logic pclk, // Processor clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic halt_instr, // Halt decoded
    input wire logic switch_or_instr, // Switch-read decoded
    input wire logic io_transfer_instr, // I/O transfer decoded
    input wire logic jump_instr, // Jump executing
    input wire logic subroutine_call_instr, // Subroutine call executing
    input wire logic set_user_cmd, // Set user flag command
    input wire logic restore_fields_cmd, // Restore fields command
    input wire logic clear_trap_cmd, // Clear trap command
    input wire logic skip_on_trap_cmd, // Skip on trap command
    input wire logic late_phase5_pulse, // Late phase five timing pulse
    input wire logic phase4_pulse, // Phase four timing pulse
    input wire logic time_state_three, // Time state three level
    input wire logic cycle_pulse_one, // Cycle pulse one
    input wire logic int_cycle_end, // Interrupt cycle finished
    input wire logic ext_int_req, // Other program interrupt requests
    input wire logic console_io_clear, // Console I/O preset
    output logic active_mode_flag, // Current mode, 1 is user
    output logic instr_abort, // Abort the decoded instruction
    output logic int_cycle, // Interrupt state
    output logic int_inhibit, // Interrupts held off
    output logic trap_skip_level_n, // Skip bus level, active low
    output logic trap_skip_oe, // Skip bus driver enable
    output logic trap_request_level_n, // Interrupt line level, active low
    output logic trap_request_oe, // Interrupt line driver enable
    output logic irq // Unmasked status pending
);
    logic active_q, active_d;
    logic pending_q, pending_d;
    logic saved_q, saved_d;
    logic trap_q, trap_d;
    logic inhibit_q, inhibit_d;
    logic intcyc_q, intcyc_d;
    logic abort_q, skip_q, req_q, irq_q;
    logic skip_n_q, req_n_q;
    logic int_en_q;
    logic [umt_pkg::EV_W-1:0] status_q, status_d, mask_q;
    logic [31:0] prdata_q, rdata_mux;
    logic pready_q, pslverr_q;

    // Bus decode; a setup cycle prepares the answer, the access edge commits it
    wire setup = psel && !penable;
    wire access = psel && penable && pready_q;
    wire [umt_pkg::ADDR_W-1:0] addr = paddr[umt_pkg::ADDR_W-1:0];
    wire sel_status = addr == umt_pkg::OFS_STATUS;
    wire sel_mask = addr == umt_pkg::OFS_MASK;
    wire sel_ctrl = addr == umt_pkg::OFS_CTRL;
    wire sel_state = addr == umt_pkg::OFS_STATE;
    wire mapped = (sel_status || sel_mask || sel_ctrl || sel_state) && (paddr[31:12] == 20'h00000);
    wire wr = access && pwrite && mapped;
    wire wr_status = wr && sel_status;
    wire wr_mask = wr && sel_mask;
    wire wr_ctrl = wr && sel_ctrl;
    // Software clear acts exactly like the console preset
    wire soft_clr = wr_ctrl && pwdata[umt_pkg::CT_SOFT_CLR];
    wire clr = console_io_clear || soft_clr;

    // Trap decode and processor interrupt request
    wire privileged = halt_instr || switch_or_instr || io_transfer_instr;
    wire trap_cond = active_q && privileged;
    wire trap_req = trap_cond || trap_q;
    wire any_req = trap_req || ext_int_req;
    wire entry = cycle_pulse_one && !intcyc_q && any_req && int_en_q && !inhibit_q;
    wire flag_load = phase4_pulse && (jump_instr || subroutine_call_instr);
    wire skip_now = skip_on_trap_cmd && trap_q;

    // Pending mode flag, a one-bit extension of the buffer field
    always_comb
    begin
        pending_d = pending_q;
        if (clr || entry)
        begin
            pending_d = 1'b0;
        end
        else if (late_phase5_pulse && set_user_cmd)
        begin
            pending_d = 1'b1;
        end
        else if (late_phase5_pulse && restore_fields_cmd)
        begin
            pending_d = saved_q;
        end
    end

    // Active mode flag; the clears win over a load in the same edge
    always_comb
    begin
        active_d = active_q;
        if (clr || (time_state_three && intcyc_q))
        begin
            active_d = 1'b0;
        end
        else if (flag_load)
        begin
            active_d = pending_q;
        end
    end

    // Saved mode flag captures the interrupted mode on entry
    always_comb
    begin
        saved_d = saved_q;
        if (clr)
        begin
            saved_d = 1'b0;
        end
        else if (entry)
        begin
            saved_d = active_q;
        end
    end

    // Trap flag; a trap at late phase five wins over the clear trap command in the same edge, but not over clr
    always_comb
    begin
        trap_d = trap_q;
        if (clr)
        begin
            trap_d = 1'b0;
        end
        else if (late_phase5_pulse)
        begin
            trap_d = trap_cond || (trap_q && !clear_trap_cmd);
        end
        else if (clear_trap_cmd)
        begin
            trap_d = 1'b0;
        end
    end

    // Interrupt hold-off from set-user until the flag is loaded
    always_comb
    begin
        inhibit_d = inhibit_q;
        if (clr || flag_load)
        begin
            inhibit_d = 1'b0;
        end
        else if (set_user_cmd)
        begin
            inhibit_d = 1'b1;
        end
    end

    // Interrupt state runs from cycle pulse one until the core ends the cycle
    always_comb
    begin
        intcyc_d = intcyc_q;
        if (clr || int_cycle_end)
        begin
            intcyc_d = 1'b0;
        end
        else if (entry)
        begin
            intcyc_d = 1'b1;
        end
    end

    // Mode and trap flip-flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pending_q <= 1'b0;
            active_q <= 1'b0;
            saved_q <= 1'b0;
            trap_q <= 1'b0;
            inhibit_q <= 1'b0;
            intcyc_q <= 1'b0;
        end
        else
        begin
            pending_q <= pending_d;
            active_q <= active_d;
            saved_q <= saved_d;
            trap_q <= trap_d;
            inhibit_q <= inhibit_d;
            intcyc_q <= intcyc_d;
        end
    end

    // Bus driver levels are registered, so they trail their cause by one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            abort_q <= 1'b0;
            skip_q <= 1'b0;
            req_q <= 1'b0;
            skip_n_q <= 1'b1;
            req_n_q <= 1'b1;
        end
        else
        begin
            abort_q <= trap_cond;
            skip_q <= skip_now;
            req_q <= trap_req;
            // Own flops for the low levels keep the pins free of output gates
            skip_n_q <= !skip_now;
            req_n_q <= !trap_req;
        end
    end

    // Sticky events; a new event beats a write-one-to-clear in the same cycle
    wire [umt_pkg::EV_W-1:0] events = {flag_load && pending_q && !active_q, entry, skip_now,
        late_phase5_pulse && trap_cond};
    wire [umt_pkg::EV_W-1:0] w1c = wr_status ? pwdata[umt_pkg::EV_W-1:0] : 4'h0;
    assign status_d = (status_q & ~w1c) | events;

    // Read selection; reserved bits read as zero
    wire [umt_pkg::ST_W-1:0] state_vec = {intcyc_q, inhibit_q, trap_q, saved_q, pending_q,
        active_q};
    assign rdata_mux = sel_status ? {28'h0000000, status_q} :
        sel_mask ? {28'h0000000, mask_q} :
        sel_ctrl ? {31'h00000000, int_en_q} :
        sel_state ? {26'h0000000, state_vec} : umt_pkg::RST_PRDATA;

    // Register file and interrupt output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q <= umt_pkg::RST_STATUS;
            mask_q <= umt_pkg::RST_MASK;
            int_en_q <= umt_pkg::RST_INT_EN;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            if (wr_mask)
            begin
                mask_q <= pwdata[umt_pkg::EV_W-1:0];
            end
            if (wr_ctrl)
            begin
                int_en_q <= pwdata[umt_pkg::CT_INT_EN];
            end
            irq_q <= |(status_d & mask_q);
        end
    end

    // APB answer: one wait-free access phase after every setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= umt_pkg::RST_PRDATA;
        end
        else
        begin
            pready_q <= setup;
            if (setup)
            begin
                pslverr_q <= !mapped;
                prdata_q <= (pwrite || !mapped) ? umt_pkg::RST_PRDATA : rdata_mux;
            end
            else if (access)
            begin
                pslverr_q <= 1'b0;
                prdata_q <= umt_pkg::RST_PRDATA;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign active_mode_flag = active_q;
    assign instr_abort = abort_q;
    assign int_cycle = intcyc_q;
    assign int_inhibit = inhibit_q;
    // Open-drain drivers pull low only while the level is asserted
    assign trap_skip_level_n = skip_n_q;
    assign trap_skip_oe = skip_q;
    assign trap_request_level_n = req_n_q;
    assign trap_request_oe = req_q;
    assign irq = irq_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_trap_decode;
        late_phase5_pulse && trap_cond && !clr;
    endsequence
    sequence s_req_at_cp1;
        cycle_pulse_one && !intcyc_q && trap_req && int_en_q && !inhibit_q && !clr
            && !int_cycle_end;
    endsequence

    property p_trap_sets;
        s_trap_decode |=> trap_q ##0 !trap_request_level_n;
    endproperty
    a_trap_sets: assert property (p_trap_sets) else $error("trap flag not set");
    property p_abort;
        trap_cond |=> instr_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort missing");
    property p_enter;
        s_req_at_cp1 |=> int_cycle ##0 saved_q == $past(active_q) ##0 !pending_q;
    endproperty
    a_enter: assert property (p_enter) else $error("interrupt entry wrong");
    property p_hold;
        trap_q && !clear_trap_cmd && !clr |=> trap_q ##1 trap_request_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("trap request dropped");
    property p_clear;
        clear_trap_cmd && !(late_phase5_pulse && trap_cond) |=> !trap_q;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_skip;
        skip_on_trap_cmd && trap_q |=> !trap_skip_level_n && trap_skip_oe;
    endproperty
    a_skip: assert property (p_skip) else $error("skip not driven");
    property p_pend;
        late_phase5_pulse && set_user_cmd && !clr && !entry |=> pending_q;
    endproperty
    a_pend: assert property (p_pend) else $error("pending not set");
    property p_load;
        flag_load && !clr && !(time_state_three && intcyc_q) |=> active_q == $past(pending_q);
    endproperty
    a_load: assert property (p_load) else $error("mode not loaded");
    property p_ts3;
        time_state_three && intcyc_q |=> !active_mode_flag;
    endproperty
    a_ts3: assert property (p_ts3) else $error("mode not cleared");
    property p_inhibit;
        inhibit_q && !intcyc_q |=> !int_cycle;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("entry while inhibited");
endmodule

/* File: tb/umt_core_model.sv */
// Purpose: Behavioural host core that issues decoded levels and timing pulses
// Assumes: One pclk domain; every level changes just after a rising edge
// Notes: The interrupt cycle runs by itself once the block enters it
`timescale 1ns/1ps
module umt_core_model (
    input wire logic pclk, // Processor clock
    input wire logic int_cycle, // Interrupt state from the block
    output logic [14:0] core_lv // Decoded levels and timing pulses
);
    logic [14:0] lv_q = 15'h0000;
    logic [1:0] ic_q = 2'h0;

    // Time state three, then one end pulse, per interrupt cycle
    always_ff @(posedge pclk)
    begin
        if (ic_q == 2'h0 && int_cycle)
            ic_q <= 2'h1;
        else if (ic_q == 2'h1 || ic_q == 2'h2)
            ic_q <= ic_q + 2'h1;
        else if (ic_q == 2'h3 && !int_cycle)
            ic_q <= 2'h0;
    end

    // Waits in state 3 so a lingering cycle never gets a second end pulse
    assign core_lv = lv_q | {1'b0, ic_q == 2'h2, ic_q == 2'h1, 12'h000};

    // Instruction level for two cycles, one timing pulse in the second
    task automatic run(input int k, input int p);
        @(posedge pclk) lv_q <= 15'h0001 << k;
        @(posedge pclk) lv_q <= (15'h0001 << k) | (15'h0001 << p);
        @(posedge pclk) lv_q <= 15'h0000;
        #1;
    endtask

    // Lone one-cycle pulse on a timing or clear line
    task automatic pulse(input int p);
        @(posedge pclk) lv_q <= 15'h0001 << p;
        @(posedge pclk) lv_q <= 15'h0000;
        #1;
    endtask
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the user-mode trap logic
// Assumes: Core levels come from the partner model; registers over APB
// Notes: State words use the package bit layout of the state register
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
    localparam logic [31:0] A_STA = {20'h00000, umt_pkg::OFS_STATUS};
    localparam logic [31:0] A_MSK = {20'h00000, umt_pkg::OFS_MASK};
    localparam logic [31:0] A_CTL = {20'h00000, umt_pkg::OFS_CTRL};
    localparam logic [31:0] A_ST = {20'h00000, umt_pkg::OFS_STATE};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [31:0] paddr = 32'h00000000, pwdata = 32'h00000000, rd, prdata;
    logic pready, pslverr, active_mode_flag, instr_abort, int_cycle, int_inhibit, irq;
    logic trap_skip_level_n, trap_skip_oe, trap_request_level_n, trap_request_oe;
    logic [14:0] cv;
    logic xreq = 1'b0;
    int n_fail = 0;
    int check_count = 0;
    // Shared buses are pulled up wherever no driver is enabled
    wire skip_bus = trap_skip_oe ? trap_skip_level_n : 1'b1;
    wire req_bus = trap_request_oe ? trap_request_level_n : 1'b1;

    umt_trap u_umt_trap (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .halt_instr(cv[0]), .switch_or_instr(cv[1]), .io_transfer_instr(cv[2]),
        .jump_instr(cv[3]), .subroutine_call_instr(cv[4]), .set_user_cmd(cv[5]),
        .restore_fields_cmd(cv[6]), .clear_trap_cmd(cv[7]), .skip_on_trap_cmd(cv[8]),
        .phase4_pulse(cv[9]), .late_phase5_pulse(cv[10]), .cycle_pulse_one(cv[11]),
        .time_state_three(cv[12]), .int_cycle_end(cv[13]), .console_io_clear(cv[14]),
        .ext_int_req(xreq), .active_mode_flag, .instr_abort, .int_cycle, .int_inhibit,
        .trap_skip_level_n, .trap_skip_oe, .trap_request_level_n, .trap_request_oe, .irq
    );
    umt_core_model u_umt_core_model (.pclk, .int_cycle, .core_lv(cv));

    // Free-running processor clock
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            n_fail++;
            tally_and_finish();
        end
        else
        begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            #1;
        end
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, e)
    endtask

    // Main sequence: mode entry, traps, interrupt cycle, skip, clears, registers
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk(A_ST, 32'h00000000);
        rchk(A_CTL, 32'h00000001);
        rchk(A_STA, 32'h00000000);
        `CHK({req_bus, skip_bus, trap_request_oe}, 3'b110)
        // Another device's request is served in executive mode
        xreq <= 1'b1;
        u_umt_core_model.pulse(11);
        `CHK(int_cycle, 1'b1)
        xreq <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        `CHK({int_cycle, active_mode_flag}, 2'b00)
        u_umt_core_model.run(0, 10);
        `CHK({instr_abort, req_bus}, 2'b01)
        u_umt_core_model.run(5, 10);
        `CHK(int_inhibit, 1'b1)
        rchk(A_ST, 32'h00000012);
        // A request must wait for the jump that loads the mode
        xreq <= 1'b1;
        u_umt_core_model.pulse(11);
        `CHK({int_cycle, int_inhibit}, 2'b01)
        xreq <= 1'b0;
        u_umt_core_model.run(3, 9);
        `CHK({active_mode_flag, int_inhibit}, 2'b10)
        rchk(A_ST, 32'h00000003);
        // Each trapped instruction kind, cleared again before the next
        for (int k = 0; k < 3; k++)
        begin
            u_umt_core_model.run(k, 10);
            `CHK({instr_abort, req_bus, trap_request_oe}, 3'b101)
            rchk(A_ST, 32'h0000000b);
            u_umt_core_model.run(7, 7);
            @(posedge pclk);
            #1;
            `CHK(req_bus, 1'b1)
        end
        u_umt_core_model.run(1, 10);
        repeat (4) @(posedge pclk);
        #1;
        `CHK(int_cycle, 1'b0)
        u_umt_core_model.pulse(11);
        `CHK({int_cycle, active_mode_flag}, 2'b11)
        repeat (3) @(posedge pclk);
        #1;
        `CHK({int_cycle, active_mode_flag}, 2'b00)
        rchk(A_ST, 32'h0000000c);
        `CHK(req_bus, 1'b0)
        u_umt_core_model.run(8, 10);
        `CHK({trap_skip_oe, skip_bus}, 2'b10)
        u_umt_core_model.run(7, 7);
        @(posedge pclk);
        #1;
        `CHK({req_bus, skip_bus}, 2'b11)
        rchk(A_ST, 32'h00000004);
        u_umt_core_model.run(6, 10);
        rchk(A_ST, 32'h00000006);
        u_umt_core_model.run(4, 9);
        `CHK(active_mode_flag, 1'b1)
        u_umt_core_model.pulse(14);
        rchk(A_ST, 32'h00000000);
        u_umt_core_model.run(6, 10);
        u_umt_core_model.run(8, 8);
        `CHK(skip_bus, 1'b1)
        rchk(A_ST, 32'h00000000);
        rchk(A_STA, 32'h0000000f);
        apb(1'b1, A_MSK, 32'h00000001);
        @(posedge pclk);
        #1;
        `CHK(irq, 1'b1)
        apb(1'b1, A_STA, 32'h00000001);
        @(posedge pclk);
        #1;
        `CHK(irq, 1'b0)
        rchk(A_STA, 32'h0000000e);
        rchk(A_MSK, 32'h00000001);
        rchk(32'h00000010, 32'h00000000);
        `CHK(er, 1'b1)
        // Soft clear acts like the console preset and reads back as zero
        u_umt_core_model.run(5, 10);
        apb(1'b1, A_CTL, 32'h00000002);
        rchk(A_ST, 32'h00000000);
        rchk(A_CTL, 32'h00000000);
        // A reset in mid-run restores the enable and empties the registers
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(A_CTL, 32'h00000001);
        rchk(A_STA, 32'h00000000);
        rchk(A_MSK, 32'h00000000);
        tally_and_finish();
    end
endmodule
